// file: include/smt_pkg.sv
package smt_pkg;
   localparam logic [3:0] ADDR_CONTROL  = 4'h0;
   localparam logic [3:0] ADDR_A_LOW    = 4'h1;
   localparam logic [3:0] ADDR_A_HIGH   = 4'h2;
   localparam logic [3:0] ADDR_B_LOW    = 4'h3;
   localparam logic [3:0] ADDR_B_HIGH   = 4'h4;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
   localparam logic [3:0] ADDR_IRQ_CLR  = 4'h6;
   localparam logic [3:0] ADDR_IRQ_EN   = 4'h7;
   localparam logic [3:0] ADDR_COMMAND  = 4'h8;
   localparam int FLD_FF       = 7;
   localparam int FLD_ACAP     = 6;
   localparam int FLD_START_HI = 5;
   localparam int FLD_START_LO = 4;
   localparam int FLD_CLK_HI   = 3;
   localparam int FLD_CLK_LO   = 2;
   localparam int FLD_MODE_HI  = 1;
   localparam int FLD_MODE_LO  = 0;
   localparam logic [7:0]  CONTROL_RESET = 8'h00;
   localparam logic [15:0] TIMER_RESET   = 16'hffff;
   localparam int DIV_WIDTH  = 11;
   localparam int TAP_SLOW   = 10;
   localparam int TAP_MID    = 6;
   localparam int TAP_FAST   = 2;
   localparam int LOW_TAP    = 2;
   typedef enum logic [1:0] {START_STOP, START_CMD, START_RISE, START_FALL} smt_start_type;
   typedef enum logic [1:0] {MODE_TIMER, MODE_WINDOW, MODE_PULSE, MODE_PPG} smt_mode_type;
endpackage

// file: include/smt_tick_if.sv
`timescale 1ns/10ps
`default_nettype none
interface smt_tick_if;
   logic tick;
   logic sel_valid;
   modport src (output tick, output sel_valid);
   modport dst (input tick, input sel_valid);
endinterface
`default_nettype wire

// file: core/smt_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module smt_prescaler
(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic [1:0] clk_sel,
   input  wire logic       div_select,
   input  wire logic       slow_mode,
   input  wire logic       low_clk,
   smt_tick_if.src         tk
);
   import smt_pkg::*;
   logic [DIV_WIDTH-1:0] div_q, div_d;
   logic [DIV_WIDTH-1:0] div_prev_q;
   logic [LOW_TAP:0]     low_q, low_d;
   logic                 low_prev_q;
   logic                 tick_d, tick_q;

   // ************************************
   // prescaler chain and tap selection
   // ************************************
   always_comb
   begin
      div_d = div_q + 1'b1;
      low_d = low_q;
      if (low_clk && !low_prev_q)
      begin
         low_d = low_q + 1'b1;
      end
      tick_d = 1'b0;
      case (clk_sel)
         2'b00:
         begin
            if (div_select || slow_mode)
               tick_d = low_q[LOW_TAP] && !low_d[LOW_TAP];
            else
               tick_d = div_prev_q[TAP_SLOW] && !div_q[TAP_SLOW];
         end
         2'b01:   tick_d = !slow_mode && div_prev_q[TAP_MID] && !div_q[TAP_MID];
         2'b10:   tick_d = !slow_mode && div_prev_q[TAP_FAST] && !div_q[TAP_FAST];
         default: tick_d = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         div_q      <= '0;
         div_prev_q <= '0;
         low_q      <= '0;
         low_prev_q <= 1'b0;
         tick_q     <= 1'b0;
      end
      else
      begin
         div_q      <= div_d;
         div_prev_q <= div_q;
         low_q      <= low_d;
         low_prev_q <= low_clk;
         tick_q     <= tick_d;
      end
   end

   assign tk.tick      = tick_q;
   assign tk.sel_valid = (clk_sel != 2'b11);
endmodule // smt_prescaler
`default_nettype wire

// file: core/smt_dbuf.sv
`timescale 1ns/10ps
`default_nettype none
module smt_dbuf
(
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        wr_low,
   input  wire logic        wr_high,
   input  wire logic [7:0]  wdata,
   input  wire logic        load_tick,
   output logic      [15:0] shadow,
   output logic      [15:0] active
);
   import smt_pkg::*;
   logic [15:0] shadow_q, shadow_d, active_q, active_d;
   logic        pend_q, pend_d;

   always_comb
   begin
      shadow_d = shadow_q;
      active_d = active_q;
      pend_d   = pend_q;
      if (wr_low)
         shadow_d[7:0] = wdata;
      if (wr_high)
      begin
         shadow_d[15:8] = wdata;
         pend_d         = 1'b1;
      end
      else if (pend_q && load_tick)
      begin
         active_d = shadow_q;
         pend_d   = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         shadow_q <= TIMER_RESET;
         active_q <= TIMER_RESET;
         pend_q   <= 1'b0;
      end
      else
      begin
         shadow_q <= shadow_d;
         active_q <= active_d;
         pend_q   <= pend_d;
      end
   end

   assign shadow = shadow_q;
   assign active = active_q;
endmodule // smt_dbuf
`default_nettype wire

// file: core/smt_timer.sv
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module smt_timer
(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       pulse_in,
   input  wire logic       low_clk,
   input  wire logic       divider_clock_select,
   input  wire logic       slow_mode,
   input  wire logic       stop_mode,
   output logic            timer_match_interrupt,
   output logic            irq,
   output logic            pulse_generator_output
);
   import smt_pkg::*;

   // ************************************
   // state
   // ************************************
   logic [7:0]  ctrl_q, ctrl_d;
   logic [15:0] cnt_q, cnt_d;
   logic [15:0] cap_q, cap_d;
   logic        run_q, run_d;
   logic        pin_q;
   logic        stop_prev_q;
   logic        stat_q, stat_d;
   logic        en_q, en_d;
   logic [7:0]  rdata_q, rdata_d;
   logic        match_q, match_d;
   logic        irq_q, irq_d;
   logic        ppg_q, ppg_d;
   logic [15:0] reg_a, reg_b, shadow_a, shadow_b;
   logic        cap_valid_q, cap_valid_d;

   smt_start_type start;
   smt_mode_type  mode;
   logic          rise, fall, trig, win_level, inc, match, stop_entry, ff_init;
   smt_tick_if    tk ();

   assign start = smt_start_type'(ctrl_q[FLD_START_HI:FLD_START_LO]);
   assign mode  = smt_mode_type'(ctrl_q[FLD_MODE_HI:FLD_MODE_LO]);
   assign ff_init = ctrl_q[FLD_FF];

   smt_prescaler u_pre
   (
      .mclk       (mclk),
      .nrst       (nrst),
      .clk_sel    (ctrl_q[FLD_CLK_HI:FLD_CLK_LO]),
      .div_select (divider_clock_select),
      .slow_mode  (slow_mode),
      .low_clk    (low_clk),
      .tk         (tk)
   );

   smt_dbuf u_a
   (
      .mclk      (mclk),
      .nrst      (nrst),
      .wr_low    (wr && addr == ADDR_A_LOW),
      .wr_high   (wr && addr == ADDR_A_HIGH),
      .wdata     (wdata),
      .load_tick (tk.tick),
      .shadow    (shadow_a),
      .active    (reg_a)
   );

   smt_dbuf u_b
   (
      .mclk      (mclk),
      .nrst      (nrst),
      .wr_low    (wr && addr == ADDR_B_LOW && mode == MODE_PPG),
      .wr_high   (wr && addr == ADDR_B_HIGH && mode == MODE_PPG),
      .wdata     (wdata),
      .load_tick (tk.tick),
      .shadow    (shadow_b),
      .active    (reg_b)
   );

   // ************************************
   // edge and level detection on the pin
   // ************************************
   always_comb
   begin
      rise       = pulse_in && !pin_q;
      fall       = !pulse_in && pin_q;
      stop_entry = stop_mode && !stop_prev_q;
      trig       = 1'b0;
      win_level  = 1'b0;
      case (start)
         START_RISE:
         begin
            trig      = rise;
            win_level = pulse_in;
         end
         START_FALL:
         begin
            trig      = fall;
            win_level = !pulse_in;
         end
         default:
         begin
            trig      = 1'b0;
            win_level = 1'b0;
         end
      endcase
   end

   // ************************************
   // counter, capture, match
   // ************************************
   always_comb
   begin
      ctrl_d      = ctrl_q;
      cnt_d       = cnt_q;
      cap_d       = cap_q;
      run_d       = run_q;
      match_d     = 1'b0;
      ppg_d       = ppg_q;
      cap_valid_d = cap_valid_q;
      inc         = 1'b0;
      if (wr && addr == ADDR_CONTROL)
         ctrl_d = wdata;
      if (wr && addr == ADDR_COMMAND && start == START_CMD)
         run_d = 1'b1;
      // timer mode with a rise or fall start counts pin edges; other modes and the command start count source ticks
      case (mode)
         MODE_TIMER:
         begin
            if (start == START_CMD)
               inc = run_q && tk.tick && tk.sel_valid;
            else
               inc = trig;
         end
         MODE_WINDOW: inc = tk.tick && win_level;
         MODE_PULSE:
         begin
            if (trig)
               run_d = 1'b1;
            inc = run_q && tk.tick;
         end
         default:
         begin
            if (trig && !run_q)
            begin
               run_d = 1'b1;
               ppg_d = ff_init;
            end
            inc = run_q && tk.tick;
         end
      endcase
      match = inc && (cnt_q + 16'h0001 == reg_a);
      if (inc)
      begin
         if (match)
         begin
            cnt_d   = '0;
            match_d = 1'b1;
         end
         else
            cnt_d = cnt_q + 16'h0001;
      end
      if (mode == MODE_PPG && inc && cnt_q + 16'h0001 == reg_b)
         ppg_d = !ppg_q;
      if (mode == MODE_PPG && match)
         ppg_d = ff_init;
      if (ctrl_q[FLD_ACAP] && mode != MODE_PULSE && mode != MODE_PPG)
      begin
         if (tk.tick)
         begin
            cap_d       = cnt_q;
            cap_valid_d = 1'b1;
         end
      end
      else
         cap_valid_d = 1'b0;
      if (start == START_STOP)
      begin
         cnt_d = '0;
         run_d = 1'b0;
         ppg_d = ff_init;
      end
      if (stop_entry)
      begin
         ctrl_d[FLD_START_HI:FLD_START_LO] = 2'b00;
         run_d = 1'b0;
      end
   end

   // ************************************
   // interrupt and register read
   // ************************************
   always_comb
   begin
      stat_d = stat_q;
      en_d   = en_q;
      if (wr && addr == ADDR_IRQ_CLR && wdata[0])
         stat_d = 1'b0;
      if (match_q)
         stat_d = 1'b1;
      if (wr && addr == ADDR_IRQ_EN)
         en_d = wdata[0];
      irq_d   = stat_d && en_d;
      rdata_d = 8'h00;
      if (rd)
      begin
         if (addr == ADDR_CONTROL)
            rdata_d = ctrl_q;
         else if (addr == ADDR_A_LOW)
            rdata_d = shadow_a[7:0];
         else if (addr == ADDR_A_HIGH)
            rdata_d = shadow_a[15:8];
         else if (addr == ADDR_B_LOW)
            rdata_d = (mode == MODE_PPG) ? shadow_b[7:0] : cap_q[7:0];
         else if (addr == ADDR_B_HIGH)
            rdata_d = (mode == MODE_PPG) ? shadow_b[15:8] : cap_q[15:8];
         else if (addr == ADDR_IRQ_STAT)
            rdata_d = {7'h00, stat_q};
         else if (addr == ADDR_IRQ_EN)
            rdata_d = {7'h00, en_q};
         else
            rdata_d = 8'h00;
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_q      <= CONTROL_RESET;
         cnt_q       <= '0;
         cap_q       <= TIMER_RESET;
         run_q       <= 1'b0;
         pin_q       <= 1'b1;
         stop_prev_q <= 1'b0;
         stat_q      <= 1'b0;
         en_q        <= 1'b0;
         rdata_q     <= 8'h00;
         match_q     <= 1'b0;
         irq_q       <= 1'b0;
         ppg_q       <= 1'b0;
         cap_valid_q <= 1'b0;
      end
      else
      begin
         ctrl_q      <= ctrl_d;
         cnt_q       <= cnt_d;
         cap_q       <= cap_d;
         run_q       <= run_d;
         pin_q       <= pulse_in;
         stop_prev_q <= stop_mode;
         stat_q      <= stat_d;
         en_q        <= en_d;
         rdata_q     <= rdata_d;
         match_q     <= match_d;
         irq_q       <= irq_d;
         ppg_q       <= ppg_d;
         cap_valid_q <= cap_valid_d;
      end
   end

   assign rdata                  = rdata_q;
   assign timer_match_interrupt  = match_q;
   assign irq                    = irq_q;
   assign pulse_generator_output = ppg_q;
endmodule // smt_timer
`default_nettype wire

// file: sim/smt_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module smt_assertions
   import smt_pkg::*;
(
   input wire logic       mclk,
   input wire logic       nrst,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       pulse_in,
   input wire logic       low_clk,
   input wire logic       divider_clock_select,
   input wire logic       slow_mode,
   input wire logic       stop_mode,
   input wire logic       timer_match_interrupt,
   input wire logic       irq,
   input wire logic       pulse_generator_output
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // ****************
   // checks
   // ****************
   sequence s_ctrl_wr;
      wr && addr == ADDR_CONTROL && !stop_mode;
   endsequence
   sequence s_ctrl_rd;
      rd && !wr && addr == ADDR_CONTROL && !stop_mode;
   endsequence
   a_ctrl_readback: assert property (s_ctrl_wr ##2 s_ctrl_rd |=> rdata == $past(wdata, 3))
      else $error("control readback differs from written value");
   a_stop_clears: assert property ($rose(stop_mode) ##1 (!wr)[*4] ##1 (rd && addr == ADDR_CONTROL)
      |=> rdata[FLD_START_HI:FLD_START_LO] == 2'h0) else $error("start field not cleared by stop");
   a_match_pulse: assert property (timer_match_interrupt |=> !timer_match_interrupt)
      else $error("match pulse longer than one cycle");
   a_irq_cause: assert property ($rose(irq) |-> $past(timer_match_interrupt) ||
      $past(timer_match_interrupt, 2) || $past(wr) || $past(wr, 2)) else $error("irq rose without cause");
   a_irq_masked: assert property ((wr && addr == ADDR_IRQ_EN && !wdata[0]) ##1 (!wr)[*3] |-> !irq)
      else $error("irq high while disabled");
   a_irq_clear: assert property (!timer_match_interrupt ##1 (wr && addr == ADDR_IRQ_CLR && wdata[0]
      && !timer_match_interrupt) ##1 (!timer_match_interrupt)[*3] |-> !irq) else $error("irq not cleared");
   a_unmapped_zero: assert property (rd && addr > ADDR_COMMAND |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
      else $error("read data outside read cycle");
   a_reset_quiet: assert property ($rose(nrst) |-> !irq && !timer_match_interrupt
      && !pulse_generator_output) else $error("outputs active after reset");
endmodule // smt_assertions
bind smt_timer smt_assertions i_chk (.mclk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .pulse_in, .low_clk,
   .divider_clock_select, .slow_mode, .stop_mode, .timer_match_interrupt, .irq, .pulse_generator_output);
`default_nettype wire

// file: sim/smt_pulse_src.sv
`timescale 1ns/10ps
`default_nettype none
module smt_pulse_src
(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic [3:0] half,
   output logic            pulse_in
);
   logic [3:0] cnt;
   // square wave, each level held half cycles; half below 2 holds the level
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt      <= 4'h0;
         pulse_in <= 1'b1;
      end
      else if (half < 4'h2)
         cnt <= 4'h0;
      else if (cnt + 4'h1 >= half)
      begin
         cnt      <= 4'h0;
         pulse_in <= ~pulse_in;
      end
      else
         cnt <= cnt + 4'h1;
   end
endmodule // smt_pulse_src
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   import smt_pkg::*;
   logic       mclk = 1'b0;
   logic       nrst = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [1:0] lcnt = 2'h0;
   logic       div_sel = 1'b0;
   logic       stop_mode = 1'b0;
   logic [3:0] half = 4'h0;
   logic [7:0] rdata;
   logic [7:0] v;
   logic [7:0] w;
   logic       pulse_in;
   logic       tmi;
   logic       irq;
   logic       pgo;
   int         errors = 0;
   int         checked = 0;
   int         gap;
   logic [1:0] tsel [4] = '{2'h0, 2'h1, 2'h0, 2'h2};
   int         tsh [4] = '{11, 7, 5, 3};
   always #25 mclk = ~mclk;
   always @(posedge mclk) lcnt <= lcnt + 2'h1;
   smt_pulse_src i_src (.mclk(mclk), .nrst(nrst), .half(half), .pulse_in(pulse_in));
   smt_timer i_dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .pulse_in(pulse_in), .low_clk(lcnt[1]), .divider_clock_select(div_sel), .slow_mode(1'b0),
      .stop_mode(stop_mode), .timer_match_interrupt(tmi), .irq(irq), .pulse_generator_output(pgo));
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // cycles between two match pulses
   task automatic gap_of(output int g);
      g = 0;
      while (tmi !== 1'b1 && g < 20000)
      begin
         @(posedge mclk);
         #1 g++;
      end
      g = 0;
      do
      begin
         @(posedge mclk);
         #1 g++;
      end
      while (tmi !== 1'b1 && g < 20000);
   endtask
   task automatic test_done();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #3000000;
      errors++;
      test_done();
   end
   initial
   begin
      int a;
      int hp;
      v = $urandom(74);
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      rreg(ADDR_CONTROL, w);
      chk("control", 16'h0000, {8'h00, w});
      for (int i = 0; i < 16; i++)
      begin
         v = $urandom;
         v[5:0] = {2'h0, 4'(i)};
         v[7] = v[7] & (v[1:0] == 2'h3);
         wreg(ADDR_CONTROL, v);
         rreg(ADDR_CONTROL, w);
         chk("control", {8'h00, v}, {8'h00, w});
      end
      rreg(4'hf, w);
      chk("unmapped", 16'h0000, {8'h00, w});
      $display("test control done");
      wreg(ADDR_IRQ_EN, 8'h01);
      wreg(ADDR_A_LOW, 8'h03);
      wreg(ADDR_A_HIGH, 8'h00);
      for (int k = 0; k < 4; k++)
      begin
         div_sel <= (k == 2);
         wreg(ADDR_CONTROL, {4'h0, tsel[k], 2'h0});
         wreg(ADDR_CONTROL, {4'h1, tsel[k], 2'h0});
         wreg(ADDR_COMMAND, 8'h01);
         gap_of(gap);
         gap_of(gap);
         chk("period", 16'(3 << tsh[k]), 16'(gap));
      end
      rreg(ADDR_IRQ_STAT, w);
      chk("status", 16'h0001, {8'h00, w});
      chk("irq", 16'h0001, {15'h0000, irq});
      gap_of(gap);
      repeat (2) @(posedge mclk);
      wreg(ADDR_IRQ_CLR, 8'h01);
      rreg(ADDR_IRQ_STAT, w);
      chk("status", 16'h0000, {8'h00, w});
      chk("irq", 16'h0000, {15'h0000, irq});
      wreg(ADDR_IRQ_EN, 8'h00);
      repeat (3) @(posedge mclk);
      gap_of(gap);
      chk("irq", 16'h0000, {15'h0000, irq});
      $display("test period done");
      wreg(ADDR_A_LOW, 8'h05);
      gap_of(gap);
      gap_of(gap);
      chk("period", 16'h0018, 16'(gap));
      wreg(ADDR_A_HIGH, 8'h00);
      gap_of(gap);
      gap_of(gap);
      chk("period", 16'h0028, 16'(gap));
      wreg(ADDR_CONTROL, 8'h58);
      repeat (16) @(posedge mclk);
      rreg(ADDR_B_LOW, w);
      chk("capture", 16'h0001, {15'h0000, w < 8'h05});
      stop_mode <= 1'b1;
      repeat (4) @(posedge mclk);
      rreg(ADDR_CONTROL, w);
      chk("control", 16'h0048, {8'h00, w});
      gap = 0;
      repeat (100)
      begin
         @(posedge mclk);
         #1 gap += int'(tmi);
      end
      chk("halted", 16'h0000, 16'(gap));
      stop_mode <= 1'b0;
      $display("test buffer stop done");
      for (int k = 2; k < 4; k++)
      begin
         a = 2 + $urandom % 6;
         hp = 2 + $urandom % 4;
         half <= 4'(hp);
         wreg(ADDR_CONTROL, 8'h08);
         wreg(ADDR_A_LOW, 8'(a));
         wreg(ADDR_A_HIGH, 8'h00);
         wreg(ADDR_CONTROL, {2'h0, 2'(k), 4'h8});
         gap_of(gap);
         gap_of(gap);
         chk("events", 16'(2 * a * hp), 16'(gap));
      end
      $display("test events done");
      wreg(ADDR_CONTROL, 8'h08);
      wreg(ADDR_CONTROL, 8'h0b);
      wreg(ADDR_B_LOW, 8'h03);
      wreg(ADDR_B_HIGH, 8'h00);
      wreg(ADDR_A_LOW, 8'h06);
      wreg(ADDR_A_HIGH, 8'h00);
      rreg(ADDR_B_LOW, w);
      chk("reg b", 16'h0003, {8'h00, w});
      wreg(ADDR_CONTROL, 8'h8b);
      repeat (2) @(posedge mclk);
      chk("ppg idle", 16'h0001, {15'h0000, pgo});
      wreg(ADDR_CONTROL, 8'h9b);
      wreg(ADDR_COMMAND, 8'h01);
      gap_of(gap);
      gap_of(gap);
      chk("ppg period", 16'h0030, 16'(gap));
      chk("ppg level", 16'h0001, {15'h0000, pgo});
      $display("test pulse done");
      test_done();
   end
endmodule // tb
`default_nettype wire
